// ### rtl/stl_status_lamps.v
// Status lamp logic of a stepper drive terminal with APB registers.
// Assumes all status inputs are synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "stl_regs.vh"

module stl_status_lamps #(
	parameter [31:0] FLASH_CYC = `STL_FLASH_CYC,
	parameter [31:0] FLICK_CYC = `STL_FLICK_CYC
) (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	// Slave state machine
	input  wire [3:0]  slaveState,
	// Encoder and digital inputs
	input  wire        encoderReady,
	input  wire        encChanA,
	input  wire        encChanB,
	input  wire        encChanC,
	input  wire        digIn1,
	input  wire        digIn2,
	// Motor stage status
	input  wire        driverReady,
	input  wire        motorSupplyOk,
	input  wire        terminalReady,
	input  wire        motorTurning,
	input  wire        motorDirCcw,
	input  wire        tempWarn,
	input  wire        dutyFull,
	input  wire        faultStageA,
	input  wire        faultStageB,
	// Commanded outputs and traffic permits
	output reg         motorEnableOut,
	output reg         digOut,
	output reg         mailboxAllow,
	output reg         processDataAllow,
	// Lamps
	output reg         runLamp,
	output reg         encoderLamp,
	output reg         chanALamp,
	output reg         chanBLamp,
	output reg         chanCLamp,
	output reg         input1Lamp,
	output reg         input2Lamp,
	output reg         driverLamp,
	output reg         powerLamp,
	output reg         clockwise_lamp,
	output reg         counterclockwise_lamp,
	output reg         enableLamp,
	output reg         warningLamp,
	output reg         errorALamp,
	output reg         errorBLamp,
	// Interrupt
	output wire        irq
);

	reg  [1:0]               ctrl_r;
	reg  [`STL_IRQ_W-1:0]    irqStat_r;
	reg  [`STL_IRQ_W-1:0]    irqStat_nxt;
	reg  [`STL_IRQ_W-1:0]    irqMask_r;
	reg  [31:0]              flashDiv_r;
	reg  [31:0]              flickDiv_r;
	reg  [3:0]               prevState_r;
	reg                      prevWarn_r;
	reg                      prevErrA_r;
	reg                      prevErrB_r;
	reg                      prevSupply_r;
	reg                      runLamp_nxt;
	reg  [31:0]              rdData;
	reg                      rdErr;
	wire [2:0]               flashPhase;
	wire [2:0]               flickPhase;
	wire [31:0]              flickEff;
	wire [`STL_LAMPS_W-1:0]  lampVec;
	wire [`STL_IRQ_W-1:0]    irqEvent;
	wire [`STL_IRQ_W-1:0]    irqClear;
	wire                     setupPh;
	wire                     wrAcc;
	wire                     motorEn;
	wire                     warnNow;
	wire                     isOp;
	wire                     isSafeOp;

	// Address is decoded once for reads and writes
	function is_reg;
		input [11:0] addr;
		input [11:0] ofs;
		begin
			is_reg = (addr == ofs);
		end
	endfunction

	assign motorEn  = ctrl_r[`STL_CTRL_MOTOR_EN];
	assign isOp     = (slaveState == `STL_ST_OP);
	assign isSafeOp = (slaveState == `STL_ST_SAFE_OPERATIONAL_STATE);
	assign warnNow  = ~motorSupplyOk | tempWarn | dutyFull;

	// APB: data captured in setup, answered in the first access cycle
	assign setupPh = psel & ~penable;
	assign pready  = psel & penable;
	assign wrAcc   = psel & penable & pwrite & ~pslverr;

	// Flicker kept clearly faster even if software misprograms it
	assign flickEff = (flickDiv_r < flashDiv_r) ? flickDiv_r
		: {2'b00, flashDiv_r[31:2]};

	stl_blink_gen u_flash (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.divCycles (flashDiv_r),
		.phase_r   (flashPhase)
	);

	stl_blink_gen u_flick (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.divCycles (flickEff),
		.phase_r   (flickPhase)
	);

	// Run lamp pattern per slave state
	always @* begin
		case (slaveState)
		`STL_ST_INIT:   runLamp_nxt = 1'b0;
		`STL_ST_PRE_OPERATIONAL_STATE:  runLamp_nxt = ~flashPhase[0];
		`STL_ST_SAFE_OPERATIONAL_STATE: runLamp_nxt = (flashPhase == 3'h0);
		`STL_ST_OP:     runLamp_nxt = 1'b1;
		`STL_ST_BOOT:   runLamp_nxt = ~flickPhase[0];
		default:        runLamp_nxt = 1'b0;
		endcase
	end

	// Lamps and commanded outputs
	always @(posedge ref_clk) begin
		if (rst) begin
			runLamp               <= 1'b0;
			encoderLamp           <= 1'b0;
			chanALamp             <= 1'b0;
			chanBLamp             <= 1'b0;
			chanCLamp             <= 1'b0;
			input1Lamp            <= 1'b0;
			input2Lamp            <= 1'b0;
			driverLamp            <= 1'b0;
			powerLamp             <= 1'b0;
			clockwise_lamp        <= 1'b0;
			counterclockwise_lamp <= 1'b0;
			enableLamp            <= 1'b0;
			warningLamp           <= 1'b0;
			errorALamp            <= 1'b0;
			errorBLamp            <= 1'b0;
			motorEnableOut        <= 1'b0;
			digOut                <= 1'b0;
			mailboxAllow          <= 1'b0;
			processDataAllow      <= 1'b0;
		end else begin
			runLamp     <= runLamp_nxt;
			encoderLamp <= encoderReady;
			chanALamp   <= encChanA;
			chanBLamp   <= encChanB;
			chanCLamp   <= encChanC;
			input1Lamp  <= digIn1;
			input2Lamp  <= digIn2;
			driverLamp  <= driverReady;
			powerLamp   <= motorSupplyOk & motorEn;
			enableLamp  <= motorEn & terminalReady;
			clockwise_lamp        <= motorTurning & ~motorDirCcw;
			counterclockwise_lamp <= motorTurning & motorDirCcw;
			warningLamp <= warnNow;
			errorALamp  <= faultStageA;
			errorBLamp  <= faultStageB;
			// Commands apply only when operational; else safe low
			motorEnableOut <= isOp & ~isSafeOp & motorEn;
			digOut         <= isOp & ~isSafeOp & ctrl_r[`STL_CTRL_DOUT];
			mailboxAllow     <= isOp;
			processDataAllow <= isOp;
		end
	end

	assign lampVec = {errorBLamp, errorALamp, warningLamp, enableLamp,
		counterclockwise_lamp, clockwise_lamp, powerLamp, driverLamp,
		input2Lamp, input1Lamp, chanCLamp, chanBLamp, chanALamp,
		encoderLamp, runLamp};

	// Interrupt events are rising edges of warning and faults, loss of supply, and any change of slave state
	assign irqEvent[`STL_IRQ_STATE]  = (slaveState != prevState_r);
	assign irqEvent[`STL_IRQ_WARN]   = warnNow & ~prevWarn_r;
	assign irqEvent[`STL_IRQ_ERRA]   = faultStageA & ~prevErrA_r;
	assign irqEvent[`STL_IRQ_ERRB]   = faultStageB & ~prevErrB_r;
	assign irqEvent[`STL_IRQ_SUPPLY] = ~motorSupplyOk & prevSupply_r;

	assign irqClear = (wrAcc & is_reg(paddr, `STL_OFS_IRQ_STAT))
		? pwdata[`STL_IRQ_W-1:0] : {`STL_IRQ_W{1'b0}};

	// Set wins over a clear in the same cycle
	always @* begin
		irqStat_nxt = (irqStat_r & ~irqClear) | irqEvent;
	end

	assign irq = |(irqStat_r & irqMask_r);

	always @(posedge ref_clk) begin
		if (rst) begin
			irqStat_r    <= {`STL_IRQ_W{1'b0}};
			prevState_r  <= `STL_ST_INIT;
			prevWarn_r   <= 1'b0;
			prevErrA_r   <= 1'b0;
			prevErrB_r   <= 1'b0;
			prevSupply_r <= 1'b0;
		end else begin
			irqStat_r    <= irqStat_nxt;
			prevState_r  <= slaveState;
			prevWarn_r   <= warnNow;
			prevErrA_r   <= faultStageA;
			prevErrB_r   <= faultStageB;
			prevSupply_r <= motorSupplyOk;
		end
	end

	// Read mux, sampled in the setup cycle
	always @* begin
		rdData = 32'h00000000;
		rdErr  = 1'b0;
		if (is_reg(paddr, `STL_OFS_CTRL))
			rdData = {30'h0, ctrl_r};
		else if (is_reg(paddr, `STL_OFS_LAMPS))
			rdData = {17'h0, lampVec};
		else if (is_reg(paddr, `STL_OFS_IRQ_STAT))
			rdData = {27'h0, irqStat_r};
		else if (is_reg(paddr, `STL_OFS_IRQ_MASK))
			rdData = {27'h0, irqMask_r};
		else if (is_reg(paddr, `STL_OFS_FLASH_DIV))
			rdData = flashDiv_r;
		else if (is_reg(paddr, `STL_OFS_FLICK_DIV))
			rdData = flickDiv_r;
		else
			rdErr = 1'b1;
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setupPh) begin
			prdata  <= pwrite ? 32'h00000000 : rdData;
			pslverr <= rdErr;
		end
	end

	// Software-writable registers, taken at the access edge
	always @(posedge ref_clk) begin
		if (rst) begin
			ctrl_r     <= `STL_CTRL_RST;
			irqMask_r  <= `STL_IRQ_MASK_RST;
			flashDiv_r <= FLASH_CYC;
			flickDiv_r <= FLICK_CYC;
		end else if (wrAcc) begin
			if (is_reg(paddr, `STL_OFS_CTRL))
				ctrl_r <= pwdata[1:0];
			if (is_reg(paddr, `STL_OFS_IRQ_MASK))
				irqMask_r <= pwdata[`STL_IRQ_W-1:0];
			if (is_reg(paddr, `STL_OFS_FLASH_DIV))
				flashDiv_r <= pwdata;
			if (is_reg(paddr, `STL_OFS_FLICK_DIV))
				flickDiv_r <= pwdata;
		end
	end

endmodule
`default_nettype wire

// ### rtl/stl_regs.vh
// Constants for the stepper terminal status lamp block.
// Assumes a 200 MHz system clock and byte addresses on APB.
`ifndef STL_REGS_VH
`define STL_REGS_VH

// Clock and lamp pattern timing
`define STL_CLK_MHZ        200
`define STL_FLASH_MS       200
`define STL_FLICK_MS       50
`define STL_FLASH_CYC      (`STL_FLASH_MS * `STL_CLK_MHZ * 1000)
`define STL_FLICK_CYC      (`STL_FLICK_MS * `STL_CLK_MHZ * 1000)
`define STL_PHASES         3'h6

// Slave state machine codes on slaveState
`define STL_ST_INIT        4'h1
`define STL_ST_PRE_OPERATIONAL_STATE       4'h2
`define STL_ST_BOOT        4'h3
`define STL_ST_SAFE_OPERATIONAL_STATE      4'h4
`define STL_ST_OP          4'h8

// Register byte offsets
`define STL_OFS_CTRL       12'h000
`define STL_OFS_LAMPS      12'h004
`define STL_OFS_IRQ_STAT   12'h008
`define STL_OFS_IRQ_MASK   12'h00C
`define STL_OFS_FLASH_DIV  12'h010
`define STL_OFS_FLICK_DIV  12'h014

// Control register fields
`define STL_CTRL_MOTOR_EN  0
`define STL_CTRL_DOUT      1
`define STL_CTRL_RST       2'h0

// Lamp readback positions
`define STL_LP_RUN         0
`define STL_LP_ENC         1
`define STL_LP_CHA         2
`define STL_LP_CHB         3
`define STL_LP_CHC         4
`define STL_LP_IN1         5
`define STL_LP_IN2         6
`define STL_LP_DRV         7
`define STL_LP_PWR         8
`define STL_LP_CW          9
`define STL_LP_CCW         10
`define STL_LP_ENA         11
`define STL_LP_WARN        12
`define STL_LP_ERRA        13
`define STL_LP_ERRB        14
`define STL_LAMPS_W        15

// Interrupt status / mask positions
`define STL_IRQ_STATE      0
`define STL_IRQ_WARN       1
`define STL_IRQ_ERRA       2
`define STL_IRQ_ERRB       3
`define STL_IRQ_SUPPLY     4
`define STL_IRQ_W          5
`define STL_IRQ_MASK_RST   5'h00

`endif

// ### rtl/stl_blink_gen.v
// Phase generator for lamp blink patterns.
// Assumes divCycles is steady for long stretches; a change stretches or cuts short the running phase.
`timescale 1ns/1ps
`default_nettype none
`include "stl_regs.vh"

module stl_blink_gen (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst,
	// Phase length in clock cycles
	input  wire [31:0] divCycles,
	// Current phase, 0 to 5
	output reg  [2:0]  phase_r
);

	reg  [31:0] count_r;
	wire [31:0] lastCount;

	// Zero would stall the counter, so treat it as one cycle
	assign lastCount = (divCycles == 32'h00000000) ? 32'h00000000
		: divCycles - 32'h00000001;

	always @(posedge ref_clk) begin
		if (rst) begin
			count_r <= 32'h00000000;
			phase_r <= 3'h0;
		end else if (count_r >= lastCount) begin
			count_r <= 32'h00000000;
			if (phase_r == `STL_PHASES - 3'h1)
				phase_r <= 3'h0;
			else
				phase_r <= phase_r + 3'h1;
		end else begin
			count_r <= count_r + 32'h00000001;
		end
	end

endmodule
`default_nettype wire

// ### test/stl_lamps_checker.sv
// Concurrent checks on the status lamp block's ports.
// Assumes binding to stl_status_lamps; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
`include "stl_regs.vh"
module stl_lamps_checker (
	// Clock and reset
	input wire       ref_clk,
	input wire       rst,
	// Status inputs
	input wire [3:0] slaveState,
	input wire       encoderReady, encChanA, encChanB, encChanC,
	input wire       digIn1, digIn2, driverReady, motorSupplyOk,
	input wire       terminalReady, motorTurning, motorDirCcw,
	input wire       tempWarn, dutyFull, faultStageA, faultStageB,
	// Outputs watched
	input wire       motorEnableOut, digOut, mailboxAllow,
	input wire       processDataAllow, runLamp, encoderLamp,
	input wire       chanALamp, chanBLamp, chanCLamp, input1Lamp,
	input wire       input2Lamp, driverLamp, powerLamp, enableLamp,
	input wire       clockwise_lamp, counterclockwise_lamp,
	input wire       warningLamp, errorALamp, errorBLamp, irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Guard on $past(rst): lamps are cleared, not copied, in reset
	a_run_op: assert property (
		slaveState == `STL_ST_OP |=> runLamp) else $error("run lamp off");
	a_run_init: assert property (
		slaveState == `STL_ST_INIT |=> !runLamp) else $error("run lamp lit");
	a_safe_outs: assert property (
		slaveState != `STL_ST_OP |=> !motorEnableOut && !digOut)
		else $error("outputs not safe");
	a_op_permits: assert property (!$past(rst) |->
		mailboxAllow == ($past(slaveState) == `STL_ST_OP) &&
		processDataAllow == mailboxAllow) else $error("permit wrong");
	a_enc_lamp: assert property (!$past(rst) |->
		encoderLamp == $past(encoderReady)) else $error("encoder lamp");
	a_chan_lamps: assert property (!$past(rst) |->
		{chanALamp, chanBLamp, chanCLamp} ==
		$past({encChanA, encChanB, encChanC})) else $error("chan lamp");
	a_input_lamps: assert property (!$past(rst) |->
		{input1Lamp, input2Lamp} == $past({digIn1, digIn2}))
		else $error("input lamp");
	a_driver_lamp: assert property (!$past(rst) |->
		driverLamp == $past(driverReady)) else $error("driver lamp");
	a_power_dark: assert property (
		!motorSupplyOk |=> !powerLamp) else $error("power lamp lit");
	a_enable_dark: assert property (
		!terminalReady |=> !enableLamp) else $error("enable lamp lit");
	a_warn_lamp: assert property (!$past(rst) |->
		warningLamp == $past(!motorSupplyOk || tempWarn || dutyFull))
		else $error("warning lamp");
	a_err_lamps: assert property (!$past(rst) |->
		{errorALamp, errorBLamp} == $past({faultStageA, faultStageB}))
		else $error("error lamp");
	a_dir_lamps: assert property (!$past(rst) |->
		clockwise_lamp == $past(motorTurning && !motorDirCcw) &&
		counterclockwise_lamp == $past(motorTurning && motorDirCcw))
		else $error("direction lamp");
	c_run_rise: cover property ($rose(runLamp));
	c_irq_rise: cover property ($rose(irq));
	c_pwr_ena: cover property (powerLamp && enableLamp);
endmodule
bind stl_status_lamps stl_lamps_checker stl_lamps_checker_i (.*);
`default_nettype wire

// ### test/stl_status_lamps_tb.sv
// Self-checking bench for the status lamp block.
// Assumes zero-wait APB slave; short blink counts keep the run brief.
`timescale 1ns/1ps
`default_nettype none
`include "stl_regs.vh"
module stl_status_lamps_tb;
	localparam int D = 24;
	logic        ref_clk = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, moEn, dO, mbA, pdA;
	logic [3:0]  slaveState = 1;
	logic [14:0] ins = 0;
	logic [14:0] lamp;
	logic [32:0] q[$];
	int          n_mismatch = 0;
	int          cmp_count = 0;
	stl_status_lamps #(.FLASH_CYC(D), .FLICK_CYC(6)) stl_status_lamps_i (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .slaveState(slaveState),
		.encoderReady(ins[14]), .encChanA(ins[13]), .encChanB(ins[12]),
		.encChanC(ins[11]), .digIn1(ins[10]), .digIn2(ins[9]),
		.driverReady(ins[8]), .motorSupplyOk(ins[7]),
		.terminalReady(ins[6]), .motorTurning(ins[5]),
		.motorDirCcw(ins[4]), .tempWarn(ins[3]), .dutyFull(ins[2]),
		.faultStageA(ins[1]), .faultStageB(ins[0]),
		.motorEnableOut(moEn), .digOut(dO), .mailboxAllow(mbA),
		.processDataAllow(pdA), .runLamp(lamp[0]), .encoderLamp(lamp[1]),
		.chanALamp(lamp[2]), .chanBLamp(lamp[3]), .chanCLamp(lamp[4]),
		.input1Lamp(lamp[5]), .input2Lamp(lamp[6]), .driverLamp(lamp[7]),
		.powerLamp(lamp[8]), .clockwise_lamp(lamp[9]),
		.counterclockwise_lamp(lamp[10]), .enableLamp(lamp[11]),
		.warningLamp(lamp[12]), .errorALamp(lamp[13]),
		.errorBLamp(lamp[14]), .irq(irq));
	initial forever #2.5 ref_clk = ~ref_clk;
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Setup on one edge, access held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!pready && n < 20);
		psel <= 0;
		penable <= 0;
		if (n >= 20) begin
			n_mismatch++;
			end_sim();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] exp);
		q.push_back(exp);
		apb(0, a, 0);
	endtask
	// Lamp word in the OP state, run lamp steady
	function automatic logic [32:0] lampExp(input logic en);
		return {18'h0, ins[0], ins[1], !ins[7] | ins[3] | ins[2],
			en & ins[6], ins[5] & ins[4], ins[5] & !ins[4], ins[7] & en,
			ins[8], ins[9], ins[10], ins[11], ins[12], ins[13], ins[14],
			1'b1};
	endfunction
	// Full pattern period, so the count does not depend on phase
	task automatic runCnt(input logic [3:0] st, input int d, input int e);
		logic [31:0] lit;
		lit = 0;
		// Four-state sum so an unknown lamp cannot count as dark
		@(posedge ref_clk);
		slaveState <= st;
		repeat (3) @(posedge ref_clk);
		repeat (6 * d) begin
			@(posedge ref_clk);
			lit += lamp[0];
		end
		check(lit, e);
	endtask
	always @(posedge ref_clk)
		if (psel && penable && pready && !pwrite)
			check({pslverr, prdata}, q.pop_front());
	initial begin
		#400000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		logic en;
		en = $urandom(53);
		repeat (10) @(posedge ref_clk);
		rst <= 0;
		rd(`STL_OFS_IRQ_MASK, 0);
		rd(`STL_OFS_CTRL, 0);
		rd(`STL_OFS_FLASH_DIV, D);
		rd(`STL_OFS_FLICK_DIV, 6);
		rd(12'h018, 33'h1_0000_0000);
		slaveState <= `STL_ST_OP;
		apb(1, `STL_OFS_LAMPS, 32'hFFFF_FFFF);
		for (int i = 0; i < 16; i++) begin
			en = $urandom;
			apb(1, `STL_OFS_CTRL, {30'h0, ~en, en});
			ins <= $urandom;
			repeat (2) @(posedge ref_clk);
			#1;
			check({moEn, dO, mbA, pdA}, {en, ~en, 2'b11});
			rd(`STL_OFS_LAMPS, lampExp(en));
		end
		runCnt(`STL_ST_INIT, D, 0);
		runCnt(4'h2, D, 3 * D);
		runCnt(4'h4, D, D);
		#1;
		check({moEn, dO, mbA, pdA}, 0);
		runCnt(`STL_ST_OP, D, 6 * D);
		apb(1, `STL_OFS_FLASH_DIV, 10);
		runCnt(4'h2, 10, 30);
		runCnt(4'h4, 10, 10);
		runCnt(`STL_ST_BOOT, 2, 6);
		runCnt(4'h5, 10, 0);
		slaveState <= `STL_ST_OP;
		ins <= 0;
		repeat (3) @(posedge ref_clk);
		apb(1, `STL_OFS_IRQ_STAT, 32'h1F);
		apb(1, `STL_OFS_IRQ_MASK, 32'h4);
		ins[1] <= 1;
		repeat (2) @(posedge ref_clk);
		#1;
		check(irq, 1);
		apb(1, `STL_OFS_IRQ_STAT, 32'h4);
		#1;
		check(irq, 0);
		@(posedge ref_clk);
		ins[0] <= 1;
		repeat (2) @(posedge ref_clk);
		#1;
		check(irq, 0);
		rd(`STL_OFS_IRQ_STAT, 33'h8);
		apb(1, `STL_OFS_IRQ_MASK, 32'h8);
		#1;
		check(irq, 1);
		end_sim();
	end
endmodule
`default_nettype wire
